// *** core/mftm_timer.sv ***
// multifunction timer: trigger, reload, capture and counting mode logic
// Functional notes
// - triggers come from soft trigger bits or pin edges, rising, falling or both
// - pin A or soft bit 0 captures or loads register 0, except bicapture
// - pin B or soft bit 1 captures register 1; no trigger loads from register 1
// - pin B may trigger register 0 when it loads and register 1 monitors
// - one-shot stops without reload at end of count; pin or soft0 restarts
// - continuous mode reloads at end of count from register 0 or alternate
// - one-shot triggered mode ignores triggers before end of count
// - one-shot retriggered mode reloads from register 0 on each trigger
// - continuous with triggered mode disables every trigger
// - gated mode counts only while selected gate pin is low
// - each holding register captures count on its trigger when capture-selected
// - pin direction overrides soft direction bit; status bit shows direction
// - free-running wraps without reload in bicapture or continuous reg0 capture
// - register 1 mirrors the counter when not capturing and not bivalue
// - clear forces 0000h counting up, FFFFh counting down
// - clear-on-capture and clear-on-compare clear counter and reload prescaler
// - biload alternates reload registers, register 0 first after bivalue rises
// - biload triggers reload register 0 and restart; one-shot uses register 0
// - bicapture alternates captures, register 0 first after bivalue cleared
// - chaining feeds prescaler from partner prescaler output; 00h matches rate
// - autodiscrimination steps once up or down by pin B/A phase order
//
// Our own choices: the Wishbone register port and the address map.
module mftm_timer
  import mftm_pkg::*;
(
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire mftm_pkg::mftm_wb_req_type wb_req_i,
  output mftm_pkg::mftm_wb_rsp_type      wb_rsp_o,
  input  wire logic                      pin_a_i,
  input  wire logic                      pin_b_i,
  input  wire logic                      chain_tick_i,
  output logic                           prescaler_tick_o,
  output logic                           end_of_count_o,
  output logic [15:0]                    counter_o
);
  import mftm_pkg::*;

  mftm_state_type  s;
  mftm_state_type  n;
  mftm_pin_fn_type fn;
  logic            req, wr, rd_en;
  logic            a_edge, b_edge, a_rise, b_rise;
  logic            soft0, soft1, clr_cmd;
  logic            trig_en, t0_raw, t1_raw, t0, t1, b_to_0;
  logic            dir_dn_now, step_ev, ext_step, src, gate_ok, active;
  logic            ptick, tick, free, eoc_now, biload;
  logic [31:0]     rd;

  function automatic logic edge_hit(input logic cur, input logic prev, input logic [1:0] sel);
    logic r;
    r = 1'b0;
    unique case (sel)
      EDGE_NONE: r = 1'b0;
      EDGE_RISE: r = cur & ~prev;
      EDGE_FALL: r = ~cur & prev;
      EDGE_BOTH: r = cur ^ prev;
    endcase
    return r;
  endfunction

  function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] d,
                                       input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = d[7:0];
    end
    if (sel[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  function automatic mftm_pin_fn_type pin_decode(input logic [3:0] code);
    mftm_pin_fn_type f;
    f = '0;
    unique case (mftm_pin_code_type'(code))
      PIN_NONE:    f = '0;
      PIN_B_TRIG:  f.b_trig = 1'b1;
      PIN_A_GATE:  f.a_gate = 1'b1;
      PIN_AG_BT:   begin f.a_gate = 1'b1; f.b_trig = 1'b1; end
      PIN_B_CLK:   f.b_clk = 1'b1;
      PIN_A_TRIG:  f.a_trig = 1'b1;
      PIN_AG_BC:   begin f.a_gate = 1'b1; f.b_clk = 1'b1; end
      PIN_AT_BT:   begin f.a_trig = 1'b1; f.b_trig = 1'b1; end
      PIN_UP_DN:   f.updn_clk = 1'b1;
      PIN_AL_BC:   begin f.a_level = 1'b1; f.b_clk = 1'b1; end
      PIN_TUP_TDN: f.trig_updn = 1'b1;
      PIN_A_LVL:   f.a_level = 1'b1;
      PIN_AUTO:    f.autodisc = 1'b1;
      PIN_AT_BC:   begin f.a_trig = 1'b1; f.b_clk = 1'b1; end
      PIN_AC_BT:   begin f.a_clk = 1'b1; f.b_trig = 1'b1; end
      PIN_AT_BG:   begin f.a_trig = 1'b1; f.b_gate = 1'b1; end
    endcase
    return f;
  endfunction

  always_comb begin
    n          = s;
    fn         = pin_decode(s.pin_code);
    rd         = '0;
    req        = wb_req_i.cyc & wb_req_i.stb & ~s.ack;
    wr         = req & wb_req_i.we;
    rd_en      = req & ~wb_req_i.we;
    soft0      = 1'b0;
    soft1      = 1'b0;
    clr_cmd    = 1'b0;
    step_ev    = 1'b0;
    dir_dn_now = s.soft_dn;
    ptick      = 1'b0;
    eoc_now    = 1'b0;
    // bus handshake: answer one cycle after the request, then drop
    n.ack = req;
    // pin synchronisers, edges seen between second and third stage
    n.a1   = pin_a_i;
    n.a2   = s.a1;
    n.a3   = s.a2;
    n.b1   = pin_b_i;
    n.b2   = s.b1;
    n.b3   = s.b2;
    a_edge = edge_hit(s.a2, s.a3, s.a_sel);
    b_edge = edge_hit(s.b2, s.b3, s.b_sel);
    a_rise = s.a2 & ~s.a3;
    b_rise = s.b2 & ~s.b3;

    // register writes
    if (wr && wb_req_i.sel[0]) begin
      unique case (wb_req_i.adr)
        MFTM_ADR_CTRL: begin
          n.soft_dn = wb_req_i.dat[CTRL_DIR];
          n.ccp     = wb_req_i.dat[CTRL_CCP];
          n.ccmp    = wb_req_i.dat[CTRL_CCMP];
          n.start   = wb_req_i.dat[CTRL_START];
          clr_cmd   = wb_req_i.dat[CTRL_CLR];
          if (wb_req_i.dat[CTRL_START] && !s.start) begin
            n.run = 1'b1;
          end
        end
        MFTM_ADR_MODE: begin
          n.one_shot = wb_req_i.dat[MODE_ONESHOT];
          n.retrig   = wb_req_i.dat[MODE_RETRIG];
          n.rm0      = wb_req_i.dat[MODE_RM0];
          n.rm1      = wb_req_i.dat[MODE_RM1];
          n.bm       = wb_req_i.dat[MODE_BM];
          n.chain    = wb_req_i.dat[MODE_CHAIN];
        end
        MFTM_ADR_FLAG: begin
          soft0 = wb_req_i.dat[FLAG_TRIG0];
          soft1 = wb_req_i.dat[FLAG_TRIG1];
        end
        MFTM_ADR_INPUT: begin
          n.a_sel    = wb_req_i.dat[ICR_A_LSB +: 2];
          n.b_sel    = wb_req_i.dat[ICR_B_LSB +: 2];
          n.pin_code = wb_req_i.dat[ICR_CODE_LSB +: 4];
        end
        MFTM_ADR_PSC: n.psc = wb_req_i.dat[7:0];
        default: ;
      endcase
    end
    if (wr) begin
      unique case (wb_req_i.adr)
        MFTM_ADR_REG0: n.reg0 = wr16(s.reg0, wb_req_i.dat, wb_req_i.sel);
        MFTM_ADR_REG1: n.reg1 = wr16(s.reg1, wb_req_i.dat, wb_req_i.sel);
        MFTM_ADR_CMP0: n.cmp0 = wr16(s.cmp0, wb_req_i.dat, wb_req_i.sel);
        default: ;
      endcase
    end

    // direction: pin assignment wins over the software bit
    if (fn.updn_clk) begin
      if (b_edge) begin
        step_ev = 1'b1;
        n.dir_dn = 1'b1;
      end else if (a_edge) begin
        step_ev = 1'b1;
        n.dir_dn = 1'b0;
      end
      dir_dn_now = n.dir_dn;
    end else if (fn.autodisc) begin
      // pin B leading pin A counts up, pin A leading pin B counts down
      if (a_rise && s.b2) begin
        step_ev = 1'b1;
        n.dir_dn = 1'b0;
      end else if (b_rise && s.a2) begin
        step_ev = 1'b1;
        n.dir_dn = 1'b1;
      end
      dir_dn_now = n.dir_dn;
    end else if (fn.trig_updn) begin
      if (b_edge) begin
        n.dir_dn = 1'b1;
      end else if (a_edge) begin
        n.dir_dn = 1'b0;
      end
      dir_dn_now = n.dir_dn;
    end else if (fn.a_level) begin
      dir_dn_now = ~s.a2;
      n.dir_dn   = ~s.a2;
    end else begin
      n.dir_dn = s.soft_dn;
    end

    // prescaler, fed by system clock, a pin edge or the partner's tick
    active   = s.start & s.run;
    ext_step = fn.updn_clk | fn.autodisc;
    gate_ok  = fn.a_gate ? ~s.a2 : (fn.b_gate ? ~s.b2 : 1'b1);
    if (fn.a_clk) begin
      src = a_edge;
    end else if (fn.b_clk) begin
      src = b_edge;
    end else if (s.chain) begin
      src = chain_tick_i;
    end else begin
      src = 1'b1;
    end
    if (active && gate_ok && src && !ext_step) begin
      if (s.pre == MFTM_PRE_ZERO) begin
        n.pre = s.psc;
        ptick = 1'b1;
      end else begin
        n.pre = s.pre - 8'h01;
      end
    end
    tick       = ext_step ? (step_ev & active) : ptick;
    n.pre_tick = ptick;

    // counting and end of count
    biload = s.bm & ~s.rm0;
    free   = (s.bm & s.rm0) | (s.rm0 & ~s.one_shot);
    if (tick) begin
      eoc_now = ~free & (dir_dn_now ? (s.cnt == MFTM_CNT_MIN) : (s.cnt == MFTM_CNT_MAX));
      if (!eoc_now) begin
        n.cnt = dir_dn_now ? s.cnt - 16'h0001 : s.cnt + 16'h0001;
      end else if (s.one_shot) begin
        n.run = 1'b0;
      end else if (biload && s.alt) begin
        n.cnt = s.reg1;
        n.alt = 1'b0;
      end else begin
        n.cnt = s.reg0;
        n.alt = biload;
      end
    end
    n.eoc = eoc_now;

    // triggers: masked while running in one-shot triggered mode, always in
    // continuous triggered mode
    trig_en = s.one_shot ? (s.retrig | ~s.run) : s.retrig;
    b_to_0  = ~s.rm0 & ~s.bm & (~s.rm1 | s.one_shot);
    t0_raw  = soft0 | (fn.a_trig & a_edge) | (b_to_0 & fn.b_trig & b_edge);
    t1_raw  = soft1 | (~b_to_0 & ~s.bm & fn.b_trig & b_edge);
    t0      = t0_raw & trig_en;
    t1      = t1_raw & trig_en;
    if (t0) begin
      if (s.rm0) begin
        if (s.bm && s.alt) begin
          n.reg1 = s.cnt;
          n.alt  = 1'b0;
        end else begin
          n.reg0 = s.cnt;
          n.alt  = s.bm;
          if (s.ccp) begin
            clr_cmd = 1'b1;
          end
        end
      end else begin
        n.cnt = s.reg0;
        n.run = 1'b1;
        n.pre = s.psc;
        n.alt = s.bm;
      end
    end
    if (t1 && s.rm1) begin
      n.reg1 = s.cnt;
    end

    // clears: direct bit, capture or compare match
    if (tick && s.ccmp && s.cnt == s.cmp0) begin
      clr_cmd = 1'b1;
    end
    if (clr_cmd) begin
      n.cnt = dir_dn_now ? MFTM_CNT_MAX : MFTM_CNT_MIN;
      n.pre = s.psc;
    end
    if (!s.bm) begin
      n.alt = 1'b0;
    end
    if (!s.rm1 && !s.bm) begin
      n.reg1 = n.cnt;
    end

    // read data
    unique case (wb_req_i.adr)
      MFTM_ADR_CTRL: begin
        rd[CTRL_DIR]   = s.soft_dn;
        rd[CTRL_CCP]   = s.ccp;
        rd[CTRL_CCMP]  = s.ccmp;
        rd[CTRL_START] = s.start;
        rd[CTRL_DSTAT] = s.dir_dn;
      end
      MFTM_ADR_MODE: begin
        rd[MODE_ONESHOT] = s.one_shot;
        rd[MODE_RETRIG]  = s.retrig;
        rd[MODE_RM0]     = s.rm0;
        rd[MODE_RM1]     = s.rm1;
        rd[MODE_BM]      = s.bm;
        rd[MODE_CHAIN]   = s.chain;
      end
      MFTM_ADR_FLAG: begin
        rd[FLAG_RUN] = s.run;
        rd[FLAG_ALT] = s.alt;
      end
      MFTM_ADR_INPUT: rd[7:0] = {s.pin_code, s.b_sel, s.a_sel};
      MFTM_ADR_REG0:  rd[15:0] = s.reg0;
      MFTM_ADR_REG1:  rd[15:0] = s.reg1;
      MFTM_ADR_CMP0:  rd[15:0] = s.cmp0;
      MFTM_ADR_CNT:   rd[15:0] = s.cnt;
      MFTM_ADR_PSC:   rd[7:0] = s.psc;
      default:        rd = '0;
    endcase
    if (rd_en) begin
      n.rdat = rd;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= MFTM_STATE_RST;
    end else begin
      s <= n;
    end
  end

  assign wb_rsp_o         = '{ack: s.ack, dat: s.rdat};
  assign prescaler_tick_o = s.pre_tick;
  assign end_of_count_o   = s.eoc;
  assign counter_o        = s.cnt;

  property p_clear;
    @(posedge clk_i) disable iff (rst_i)
      (wr && wb_req_i.sel[0] && wb_req_i.adr == MFTM_ADR_CTRL && wb_req_i.dat[CTRL_CLR])
      |=> (s.cnt == ($past(dir_dn_now) ? MFTM_CNT_MAX : MFTM_CNT_MIN));
  endproperty
  a_clear: assert property (p_clear) else $error("clear value wrong");

  property p_one_shot_stop;
    @(posedge clk_i) disable iff (rst_i)
      (eoc_now && s.one_shot && !t0 && !clr_cmd) |=> (!s.run && $stable(s.cnt));
  endproperty
  a_one_shot_stop: assert property (p_one_shot_stop) else $error("one-shot kept running");

  property p_reload;
    @(posedge clk_i) disable iff (rst_i)
      (eoc_now && !s.one_shot && !biload && !t0 && !clr_cmd && !wr)
      |=> (s.cnt == $past(s.reg0));
  endproperty
  a_reload: assert property (p_reload) else $error("no reload from register 0");

  property p_trig_mask;
    @(posedge clk_i) disable iff (rst_i)
      (s.one_shot && !s.retrig && s.run) |-> !t0 && !t1;
  endproperty
  a_trig_mask: assert property (p_trig_mask) else $error("trigger taken while running");

  property p_cont_no_trig;
    @(posedge clk_i) disable iff (rst_i)
      (!s.one_shot && !s.retrig && t0_raw) |=> $stable(s.reg0) || $past(wr);
  endproperty
  a_cont_no_trig: assert property (p_cont_no_trig) else $error("trigger acted");

  property p_gate;
    @(posedge clk_i) disable iff (rst_i)
      (fn.a_gate && s.a2 && !ext_step && !t0 && !clr_cmd && !wr) |=> $stable(s.pre);
  endproperty
  a_gate: assert property (p_gate) else $error("prescaler ran with gate high");

  property p_monitor;
    @(posedge clk_i) disable iff (rst_i)
      ($past(!s.rm1 && !s.bm) && !$past(rst_i)) |-> (s.reg1 == s.cnt);
  endproperty
  a_monitor: assert property (p_monitor) else $error("register 1 not mirroring");

  property p_bicap_alt;
    @(posedge clk_i) disable iff (rst_i)
      (t0 && s.rm0 && s.bm && s.alt) |=> (s.reg1 == $past(s.cnt)) && !s.alt;
  endproperty
  a_bicap_alt: assert property (p_bicap_alt) else $error("bicapture did not alternate");

  property p_ack;
    @(posedge clk_i) disable iff (rst_i)
      (wb_req_i.cyc && wb_req_i.stb && !s.ack) |=> s.ack ##1 !s.ack;
  endproperty
  a_ack: assert property (p_ack) else $error("bus ack not one cycle");
endmodule // mftm_timer

// *** core/mftm_pkg.sv ***
// constants and types shared by the multifunction timer mode logic
package mftm_pkg;
  // register byte addresses, one aligned word each
  localparam logic [7:0] MFTM_ADR_CTRL  = 8'h00;
  localparam logic [7:0] MFTM_ADR_MODE  = 8'h04;
  localparam logic [7:0] MFTM_ADR_FLAG  = 8'h08;
  localparam logic [7:0] MFTM_ADR_INPUT = 8'h0C;
  localparam logic [7:0] MFTM_ADR_REG0  = 8'h10;
  localparam logic [7:0] MFTM_ADR_REG1  = 8'h14;
  localparam logic [7:0] MFTM_ADR_CMP0  = 8'h18;
  localparam logic [7:0] MFTM_ADR_CNT   = 8'h1C;
  localparam logic [7:0] MFTM_ADR_PSC   = 8'h20;
  // timer_control_reg bits
  localparam int CTRL_DIR   = 0;
  localparam int CTRL_CLR   = 1;
  localparam int CTRL_CCP   = 2;
  localparam int CTRL_CCMP  = 3;
  localparam int CTRL_START = 4;
  localparam int CTRL_DSTAT = 5;
  // timer_mode_reg bits
  localparam int MODE_ONESHOT = 0;
  localparam int MODE_RETRIG  = 1;
  localparam int MODE_RM0     = 2;
  localparam int MODE_RM1     = 3;
  localparam int MODE_BM      = 4;
  localparam int MODE_CHAIN   = 5;
  // timer_flag_reg bits
  localparam int FLAG_TRIG0 = 0;
  localparam int FLAG_TRIG1 = 1;
  localparam int FLAG_RUN   = 2;
  localparam int FLAG_ALT   = 3;
  // input_control_reg fields
  localparam int ICR_A_LSB    = 0;
  localparam int ICR_B_LSB    = 2;
  localparam int ICR_CODE_LSB = 4;
  localparam logic [1:0] EDGE_NONE    = 2'h0;
  localparam logic [1:0] EDGE_RISE    = 2'h1;
  localparam logic [1:0] EDGE_FALL    = 2'h2;
  localparam logic [1:0] EDGE_BOTH    = 2'h3;
  localparam logic [15:0] MFTM_CNT_MIN = 16'h0000;
  localparam logic [15:0] MFTM_CNT_MAX = 16'hFFFF;
  localparam logic [7:0]  MFTM_PRE_ZERO = 8'h00;

  typedef enum logic [3:0] {
    PIN_NONE = 4'h0, PIN_B_TRIG = 4'h1, PIN_A_GATE = 4'h2, PIN_AG_BT = 4'h3,
    PIN_B_CLK = 4'h4, PIN_A_TRIG = 4'h5, PIN_AG_BC = 4'h6, PIN_AT_BT = 4'h7,
    PIN_UP_DN = 4'h8, PIN_AL_BC = 4'h9, PIN_TUP_TDN = 4'hA, PIN_A_LVL = 4'hB,
    PIN_AUTO = 4'hC, PIN_AT_BC = 4'hD, PIN_AC_BT = 4'hE, PIN_AT_BG = 4'hF
  } mftm_pin_code_type;

  typedef struct packed {
    logic a_trig;
    logic b_trig;
    logic a_gate;
    logic b_gate;
    logic a_clk;
    logic b_clk;
    logic updn_clk;
    logic a_level;
    logic trig_updn;
    logic autodisc;
  } mftm_pin_fn_type;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } mftm_wb_req_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } mftm_wb_rsp_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdat;
    logic        a1, a2, a3, b1, b2, b3;
    logic        soft_dn, ccp, ccmp, start;
    logic        one_shot, retrig, rm0, rm1, bm, chain;
    logic [1:0]  a_sel, b_sel;
    logic [3:0]  pin_code;
    logic [15:0] reg0, reg1, cmp0, cnt;
    logic [7:0]  psc, pre;
    logic        run, alt, dir_dn, pre_tick, eoc;
  } mftm_state_type;

  localparam mftm_state_type MFTM_STATE_RST = '0;
endpackage

// *** testbench/mftm_pin_model.sv ***
// far-side model: input pins and the partner timer's prescaler tick
module mftm_pin_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] want_i,
  input  wire logic       slow_i,
  output logic            pin_a_o,
  output logic            pin_b_o,
  output logic            chain_tick_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] stage_ff [3];
  logic       tick_ff;

  // levels are held for whole cycles, so every edge outlasts the pulse width minimum
  always_ff @(posedge clk_i) begin
    stage_ff[0] <= want_i;
    stage_ff[1] <= stage_ff[0];
    stage_ff[2] <= stage_ff[1];
  end
  // slow mode delays the edge by two more cycles; the bench timing allows both
  assign {pin_b_o, pin_a_o} = slow_i ? stage_ff[2] : stage_ff[0];

  // partner prescaler runs at half the system clock rate
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= !tick_ff;
    end
  end
  assign chain_tick_o = tick_ff;
endmodule // mftm_pin_model

// *** testbench/test_multifunction_timer_modes.sv ***
// self-checking bench for the timer mode logic
module test_multifunction_timer_modes;
  timeunit 1ns;
  timeprecision 1ps;
  import mftm_pkg::*;
  logic                      clk_i;
  logic                      rst_i;
  mftm_pkg::mftm_wb_req_type wb_req;
  mftm_pkg::mftm_wb_rsp_type wb_rsp;
  logic                      pin_a, pin_b, chain_tick, pre_tick, end_of_count_o;
  logic [15:0]               counter_o;
  logic [1:0]                want;
  logic                      slow;
  int                        errors, checks_done;

  mftm_timer mftm_timer_i (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
    .pin_a_i(pin_a), .pin_b_i(pin_b), .chain_tick_i(chain_tick),
    .prescaler_tick_o(pre_tick), .end_of_count_o(end_of_count_o), .counter_o(counter_o));
  mftm_pin_model mftm_pin_model_i (.clk_i(clk_i), .rst_i(rst_i), .want_i(want), .slow_i(slow),
    .pin_a_o(pin_a), .pin_b_o(pin_b), .chain_tick_o(chain_tick));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = !clk_i;
  end

  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one classic cycle; ack is read as it stood before the edge
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                          output logic [31:0] rdat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_req <= '{1'b1, 1'b1, we, adr, 4'hF, dat};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_rsp.ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      $display("CHECK FAILED ack expected 1 seen 0");
    end
    rdat = wb_rsp.dat;
    wb_req <= '0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] d;
    wb_cycle(1'b1, adr, dat, d);
  endtask

  task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input string what);
    logic [31:0] d;
    wb_cycle(1'b0, adr, 32'h0, d);
    check(what, d, exp);
  endtask

  task automatic rd_val(input logic [7:0] adr, output logic [31:0] d);
    wb_cycle(1'b0, adr, 32'h0, d);
  endtask

  // cycles from the previous call's sample to the next end of count
  task automatic wait_eoc(output int t);
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (end_of_count_o !== 1'b1 && t < 70000);
  endtask

  function automatic int period(input logic [15:0] r0, input int p, input int ch);
    return (32'h10000 - r0) * (p + 1) * (ch + 1);
  endfunction

  initial begin
    repeat (90000) @(posedge clk_i);
    errors++;
    close_out();
  end

  initial begin
    logic [15:0] r0, c;
    logic [31:0] d, m;
    int          p, q, t, t2;
    wb_req = '0;
    want = 2'b00;
    slow = 1'b0;
    errors = 0;
    checks_done = 0;
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    void'($urandom(32'hF3FB));
    rd(MFTM_ADR_CNT, 32'h0, "counter reset");
    rd(8'h30, 32'h0, "unmapped read");
    // a clear uses the direction already in force, so direction goes first
    wr(MFTM_ADR_CTRL, 1 << CTRL_DIR);
    wr(MFTM_ADR_CTRL, (1 << CTRL_DIR) | (1 << CTRL_CLR));
    rd(MFTM_ADR_CNT, 32'hFFFF, "clear down");
    rd(MFTM_ADR_CTRL, (1 << CTRL_DIR) | (1 << CTRL_DSTAT), "dir");
    wr(MFTM_ADR_CTRL, 32'h0);
    wr(MFTM_ADR_CTRL, 1 << CTRL_CLR);
    rd(MFTM_ADR_CNT, 32'h0, "clear up");
    wr(MFTM_ADR_CTRL, 1 << CTRL_START);
    // continuous reload, system clock then chained clock
    for (int ch = 0; ch < 2; ch++) begin
      r0 = 16'hFFC0 | 16'($urandom_range(0, 31));
      p = $urandom_range(0, 3);
      wr(MFTM_ADR_REG0, {16'h0, r0});
      wr(MFTM_ADR_PSC, 32'(p));
      wr(MFTM_ADR_MODE, (1 << MODE_RETRIG) | (ch << MODE_CHAIN));
      wr(MFTM_ADR_FLAG, 1 << FLAG_TRIG0);
      wait_eoc(t);
      wait_eoc(t);
      check("reload period", 32'(t), 32'(period(r0, p, ch)));
    end
    // biload: register 0 first after the bivalue bit rises
    wr(MFTM_ADR_PSC, 32'h0);
    wr(MFTM_ADR_REG0, 32'hFFF0);
    wr(MFTM_ADR_MODE, 1 << MODE_RETRIG);
    wr(MFTM_ADR_FLAG, 1 << FLAG_TRIG0);
    wr(MFTM_ADR_MODE, (1 << MODE_RETRIG) | (1 << MODE_BM));
    // register 1 mirrors the count until the bivalue bit is up
    wr(MFTM_ADR_REG1, 32'hFFE0);
    wait_eoc(t);
    wait_eoc(t);
    wait_eoc(t2);
    check("biload first", 32'(t), 32'd16);
    check("biload second", 32'(t2), 32'd32);
    // one-shot stops, then triggered ignores and retriggered reloads
    wr(MFTM_ADR_REG0, 32'hFFC0);
    wr(MFTM_ADR_MODE, 1 << MODE_ONESHOT);
    wait_eoc(t);
    c = counter_o;
    repeat (20) @(posedge clk_i);
    check("stopped count", {16'h0, counter_o}, {16'h0, c});
    rd(MFTM_ADR_FLAG, 32'h0, "running after stop");
    for (int k = 0; k < 2; k++) begin
      wr(MFTM_ADR_MODE, (1 << MODE_ONESHOT) | (k << MODE_RETRIG));
      wr(MFTM_ADR_FLAG, 1 << FLAG_TRIG0);
      repeat (30) @(posedge clk_i);
      wr(MFTM_ADR_FLAG, 1 << FLAG_TRIG0);
      wait_eoc(t);
      check("restart and retrigger", {31'h0, t < 48}, {31'h0, k == 0});
    end
    // continuous and triggered: soft capture must be blocked
    wr(MFTM_ADR_MODE, 1 << MODE_RM0);
    wr(MFTM_ADR_REG0, 32'h1234);
    wr(MFTM_ADR_CTRL, 32'h0);
    wr(MFTM_ADR_CTRL, 1 << CTRL_START);
    wr(MFTM_ADR_FLAG, 1 << FLAG_TRIG0);
    rd(MFTM_ADR_REG0, 32'h1234, "blocked capture");
    // pin A capture, monitor on register 1, free-running wrap
    slow <= 1'($urandom_range(0, 1));
    wr(MFTM_ADR_MODE, (1 << MODE_RM0) | (1 << MODE_RETRIG));
    wr(MFTM_ADR_INPUT, 32'(EDGE_RISE) | (32'(PIN_A_TRIG) << ICR_CODE_LSB));
    @(posedge clk_i);
    want <= 2'b01;
    c = counter_o;
    repeat (10) @(posedge clk_i);
    rd_val(MFTM_ADR_REG0, d);
    check("pin capture", {31'h0, (d[15:0] - c) inside {[1 : 10]}}, 32'h1);
    rd_val(MFTM_ADR_REG1, m);
    check("monitor", {31'h0, (counter_o - m[15:0]) <= 4}, 32'h1);
    p = 0;
    q = 0;
    repeat (65600) begin
      @(posedge clk_i);
      if (end_of_count_o !== 1'b0) p++;
      if (pre_tick === 1'b1) q++;
    end
    check("free-running eoc", 32'(p), 32'h0);
    check("prescaler ticks", 32'(q), 32'd65600);
    // bicapture: two soft captures three cycles apart, register 0 then 1
    wr(MFTM_ADR_MODE, (1 << MODE_RM0) | (1 << MODE_RETRIG) | (1 << MODE_BM));
    wr(MFTM_ADR_FLAG, 1 << FLAG_TRIG0);
    wr(MFTM_ADR_FLAG, 1 << FLAG_TRIG0);
    rd_val(MFTM_ADR_REG0, d);
    rd_val(MFTM_ADR_REG1, m);
    check("bicapture", 32'(16'(m[15:0] - d[15:0])), 32'd3);
    // clear on capture: count restarts from zero, read two cycles later
    wr(MFTM_ADR_CTRL, (1 << CTRL_START) | (1 << CTRL_CCP));
    wr(MFTM_ADR_FLAG, 1 << FLAG_TRIG0);
    rd(MFTM_ADR_CNT, 32'h2, "clear on capture");
    // gate on pin A: high holds the count
    wr(MFTM_ADR_INPUT, 32'(PIN_A_GATE) << ICR_CODE_LSB);
    repeat (6) @(posedge clk_i);
    c = counter_o;
    repeat (10) @(posedge clk_i);
    check("gate high holds", {16'h0, counter_o}, {16'h0, c});
    want <= 2'b00;
    repeat (10) @(posedge clk_i);
    check("gate low counts", {31'h0, counter_o !== c}, 32'h1);
    // level on pin A low selects down over the soft bit
    wr(MFTM_ADR_INPUT, 32'(PIN_A_LVL) << ICR_CODE_LSB);
    repeat (6) @(posedge clk_i);
    m = (1 << CTRL_START) | (1 << CTRL_CCP) | (1 << CTRL_DSTAT);
    rd(MFTM_ADR_CTRL, m, "pin dir");
    close_out();
  end
endmodule // test_multifunction_timer_modes
